// File: include/bsx_pkg.sv
// Operation
// RULE1: unconditional branch loads target, second cycle idles
// RULE2: target is incremented pc plus twice offset
// RULE3: opcode 1000 forces selected bit to one
// RULE4: opcode 1011 skips next when bit clear
// RULE5: skip discards prefetch, runs one idle cycle
// RULE6: skipped two-word instruction adds another idle cycle
// RULE7: access bit zero picks access bank
// RULE8: opcode 0111 inverts selected bit
// RULE9: branch on overflow only when flag set
// RULE10: opcode 1010 skips next when bit set
// RULE11: read in Q2, modify Q3, write Q4
`default_nettype none
package bsx_pkg;
    localparam int          PC_W           = 21;
    localparam logic [3:0]  OPC_BIT_SET    = 4'h8;
    localparam logic [3:0]  OPC_BIT_TOGGLE = 4'h7;
    localparam logic [3:0]  OPC_SKIP_CLR   = 4'hB;
    localparam logic [3:0]  OPC_SKIP_SET   = 4'hA;
    localparam logic [3:0]  OPC_UNCOND_BR  = 4'hD;
    localparam logic [3:0]  OPC_COND_BR    = 4'hE;
    localparam logic [3:0]  SUB_OVF_BR     = 4'h4;
    localparam logic [7:0]  ACCESS_SPLIT   = 8'h80;
    localparam logic [3:0]  ACCESS_LO_BANK = 4'h0;
    localparam logic [3:0]  ACCESS_HI_BANK = 4'hF;
    localparam logic [1:0]  PH_Q1          = 2'h0;
    localparam logic [1:0]  PH_Q2          = 2'h1;
    localparam logic [1:0]  PH_Q3          = 2'h2;
    localparam logic [1:0]  PH_Q4          = 2'h3;

    typedef enum logic [2:0] {
        BSX_OP_NONE, BSX_OP_SET, BSX_OP_TGL, BSX_OP_TSC, BSX_OP_TSS, BSX_OP_UBR, BSX_OP_OVB
    } bsx_op_type;

    typedef enum logic [1:0] {
        BSX_EXEC, BSX_NOP1, BSX_NOP2
    } bsx_mode_type;

    typedef struct packed {
        logic [1:0]      phase;
        bsx_mode_type    mode;
        bsx_op_type      op;
        logic [2:0]      bitsel;
        logic [11:0]     faddr;
        logic [PC_W-1:0] target;
        logic            take;
        logic            skip2;
        logic            rd;
        logic            wr;
        logic [7:0]      wdata;
        logic            pc_load;
        logic            discard;
        logic            nop;
    } bsx_state_type;
endpackage : bsx_pkg
`default_nettype wire

// File: hdl/bsx_exec.sv
`default_nettype none
module bsx_exec
    import bsx_pkg::*;
(
    // clock and reset
    input  wire logic            i_core_clk,
    input  wire logic            i_sys_rst,
    // instruction stream
    input  wire logic [15:0]     i_instr,
    input  wire logic            i_instr_valid,
    input  wire logic [PC_W-1:0] i_pc,
    input  wire logic            i_next_two_word,
    // core state
    input  wire logic            i_ovf,
    input  wire logic [3:0]      i_bank_sel,
    input  wire logic [7:0]      i_fdata,
    // file register access
    output logic                 o_rd_en,
    output logic                 o_wr_en,
    output logic [11:0]          o_faddr,
    output logic [7:0]           o_wdata,
    // program flow
    output logic                 o_pc_load,
    output logic [PC_W-1:0]      o_pc_target,
    output logic                 o_discard,
    output logic                 o_nop_cycle,
    output logic [1:0]           o_phase
);
    bsx_state_type s;
    bsx_state_type next_s;

    function automatic bsx_op_type decode_op(input logic [15:0] w);
        bsx_op_type r;
        r = BSX_OP_NONE;
        if (w[15:12] == OPC_BIT_SET) begin
            r = BSX_OP_SET;
        end else if (w[15:12] == OPC_BIT_TOGGLE) begin
            r = BSX_OP_TGL;
        end else if (w[15:12] == OPC_SKIP_CLR) begin
            r = BSX_OP_TSC;
        end else if (w[15:12] == OPC_SKIP_SET) begin
            r = BSX_OP_TSS;
        end else if (w[15:12] == OPC_UNCOND_BR && !w[11]) begin
            r = BSX_OP_UBR;
        end else if (w[15:12] == OPC_COND_BR && w[11:8] == SUB_OVF_BR) begin
            r = BSX_OP_OVB;
        end
        return r;
    endfunction : decode_op

    // pc is already incremented past this word
    function automatic logic [PC_W-1:0] branch_target(input logic [PC_W-1:0] pc,
                                                      input logic signed [10:0] off);
        logic [PC_W-1:0] ext;
        ext = PC_W'(off);
        return pc + {ext[PC_W-2:0], 1'b0}; // [RULE2]
    endfunction : branch_target

    function automatic logic [11:0] bank_addr(input logic a, input logic [7:0] f, input logic [3:0] bsel);
        logic [3:0] bank;
        bank = bsel;
        if (!a) begin
            bank = (f < ACCESS_SPLIT) ? ACCESS_LO_BANK : ACCESS_HI_BANK; // [RULE7]
        end
        return {bank, f};
    endfunction : bank_addr

    function automatic logic [10:0] offset_of(input logic [15:0] w, input bsx_op_type op);
        return (op == BSX_OP_UBR) ? w[10:0] : {{3{w[7]}}, w[7:0]};
    endfunction : offset_of

    bsx_op_type      dec_op;
    logic [7:0]      mask;
    logic            sel_bit;

    always_comb begin
        dec_op  = decode_op(i_instr);
        mask    = 8'h01 << s.bitsel;
        sel_bit = |(i_fdata & mask);
        next_s  = s;
        next_s.phase   = s.phase + 2'h1;
        next_s.rd      = 1'b0;
        next_s.wr      = 1'b0;
        next_s.pc_load = 1'b0;
        next_s.discard = 1'b0;
        case (s.mode)
            BSX_EXEC: begin
                case (s.phase)
                    PH_Q1: begin
                        next_s.op   = i_instr_valid ? dec_op : BSX_OP_NONE;
                        next_s.bitsel = i_instr[11:9];
                        next_s.faddr  = bank_addr(i_instr[8], i_instr[7:0], i_bank_sel);
                        next_s.target = branch_target(i_pc, offset_of(i_instr, dec_op));
                        // overflow is sampled at decode
                        next_s.take = i_instr_valid &&
                                      (dec_op == BSX_OP_UBR || (dec_op == BSX_OP_OVB && i_ovf)); // [RULE9]
                        next_s.rd   = i_instr_valid && (dec_op == BSX_OP_SET || dec_op == BSX_OP_TGL ||
                                      dec_op == BSX_OP_TSC || dec_op == BSX_OP_TSS); // [RULE11]
                    end
                    PH_Q3: begin
                        if (s.op == BSX_OP_SET) begin
                            next_s.wr    = 1'b1; // [RULE11]
                            next_s.wdata = i_fdata | mask; // [RULE3]
                        end else if (s.op == BSX_OP_TGL) begin
                            next_s.wr    = 1'b1;
                            next_s.wdata = i_fdata ^ mask; // [RULE8]
                        end
                        next_s.pc_load = s.take; // [RULE1]
                        if ((s.op == BSX_OP_TSC && !sel_bit) || (s.op == BSX_OP_TSS && sel_bit)) begin
                            next_s.discard = 1'b1; // [RULE4] [RULE10] [RULE5]
                            next_s.skip2   = i_next_two_word;
                        end else begin
                            next_s.skip2   = 1'b0;
                        end
                    end
                    PH_Q4: begin
                        if (s.discard && s.skip2) begin
                            next_s.mode = BSX_NOP2; // [RULE6]
                        end else if (s.discard || s.pc_load) begin
                            next_s.mode = BSX_NOP1; // [RULE1] [RULE5]
                        end
                        next_s.op = BSX_OP_NONE;
                    end
                    default: begin
                    end
                endcase
            end
            BSX_NOP2: begin
                if (s.phase == PH_Q4) begin
                    next_s.mode = BSX_NOP1;
                end
            end
            default: begin
                if (s.phase == PH_Q4) begin
                    next_s.mode = BSX_EXEC;
                end
            end
        endcase
        next_s.nop = (next_s.mode != BSX_EXEC);
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign o_rd_en     = s.rd;
    assign o_wr_en     = s.wr;
    assign o_faddr     = s.faddr;
    assign o_wdata     = s.wdata;
    assign o_pc_load   = s.pc_load;
    assign o_pc_target = s.target;
    assign o_discard   = s.discard;
    assign o_nop_cycle = s.nop;
    assign o_phase     = s.phase;

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_sys_rst);

    // decode accepted on this edge
    logic accept;
    assign accept = s.mode == BSX_EXEC && s.phase == PH_Q1 && i_instr_valid;

    a_set_bit_one: assert property (s.phase == PH_Q3 && s.op == BSX_OP_SET |=> // [RULE3]
        o_wr_en && o_wdata == ($past(i_fdata) | (8'h01 << s.bitsel)))
        else $error("bit set wrote wrong data");
    a_toggle_bit_inv: assert property (s.phase == PH_Q3 && s.op == BSX_OP_TGL |=> // [RULE8]
        o_wr_en && o_wdata == ($past(i_fdata) ^ (8'h01 << s.bitsel)))
        else $error("bit toggle wrote wrong data");
    a_branch_target: assert property (accept && dec_op == BSX_OP_UBR |-> // [RULE2]
        ##3 o_pc_load && o_pc_target == $past(branch_target(i_pc, i_instr[10:0]), 3))
        else $error("branch target wrong");
    a_ovf_br_target: assert property (accept && dec_op == BSX_OP_OVB && i_ovf |-> // [RULE2]
        ##3 o_pc_target == $past(i_pc + {{12{i_instr[7]}}, i_instr[7:0], 1'b0}, 3))
        else $error("overflow branch target wrong");
    a_ovf_br_idle: assert property (accept && dec_op == BSX_OP_OVB && !i_ovf |-> ##3 !o_pc_load) // [RULE9]
        else $error("overflow branch taken with flag clear");
    a_ovf_br_taken: assert property (accept && dec_op == BSX_OP_OVB && i_ovf |-> ##3 o_pc_load) // [RULE9]
        else $error("overflow branch not taken with flag set");
    // skip decision uses the read data of this same clock
    a_skip_clear_bit: assert property (s.mode == BSX_EXEC && s.phase == PH_Q3 && s.op == BSX_OP_TSC && // [RULE4]
        !(|(i_fdata & (8'h01 << s.bitsel))) |=> o_discard)
        else $error("skip on clear missed");
    a_skip_clr_hold: assert property (s.phase == PH_Q3 && s.op == BSX_OP_TSC && // [RULE4]
        (|(i_fdata & (8'h01 << s.bitsel))) |=> !o_discard)
        else $error("skip on clear fired on set bit");
    a_skip_set_bit: assert property (s.phase == PH_Q3 && s.op == BSX_OP_TSS && // [RULE10]
        !(|(i_fdata & (8'h01 << s.bitsel))) |=> !o_discard)
        else $error("skip on set fired on clear bit");
    a_skip_set_fire: assert property (s.mode == BSX_EXEC && s.phase == PH_Q3 && s.op == BSX_OP_TSS && // [RULE10]
        (|(i_fdata & (8'h01 << s.bitsel))) |=> o_discard)
        else $error("skip on set missed");
    a_skip_one_nop: assert property (o_discard && !s.skip2 |=> o_nop_cycle [*4] ##1 !o_nop_cycle) // [RULE5]
        else $error("single skip idle cycle wrong");
    a_skip_two_nop: assert property (o_discard && s.skip2 |=> o_nop_cycle [*8] ##1 !o_nop_cycle) // [RULE6]
        else $error("two-word skip idle cycles wrong");
    a_skip_no_write: assert property (o_discard |-> !o_wr_en && !o_pc_load) // [RULE5]
        else $error("skip wrote or branched");
    a_branch_nop: assert property (o_pc_load |=> o_nop_cycle [*4]) // [RULE1]
        else $error("branch second cycle not idle");
    a_access_bank: assert property (accept && !i_instr[8] && i_instr[7:0] < ACCESS_SPLIT && // [RULE7]
        dec_op == BSX_OP_SET |=> o_rd_en && o_faddr[11:8] == ACCESS_LO_BANK)
        else $error("access bank not selected");
    a_bank_select: assert property (accept && i_instr[8] && // [RULE7]
        (dec_op == BSX_OP_SET || dec_op == BSX_OP_TGL) |=> o_faddr == {$past(i_bank_sel), $past(i_instr[7:0])})
        else $error("bank select register not used");
    a_rmw_rd_phase: assert property (o_rd_en |-> o_phase == PH_Q2) // [RULE11]
        else $error("read in wrong phase");
    a_rmw_wr_phase: assert property (o_wr_en |-> o_phase == PH_Q4) // [RULE11]
        else $error("write in wrong phase");
    a_rd_pulse_one: assert property (o_rd_en |=> !o_rd_en) // [RULE11]
        else $error("read strobe longer than one clock");

    c_skip_two: cover property (o_discard && s.skip2);
    c_skip_one: cover property (o_discard && !s.skip2);
    c_uncond_br: cover property (o_pc_load && s.op == BSX_OP_UBR);
    c_ovf_taken: cover property (o_pc_load && s.op == BSX_OP_OVB);
    c_toggle: cover property (o_wr_en && s.op == BSX_OP_TGL);
endmodule : bsx_exec
`default_nettype wire

// File: sim/tb_top.sv
`default_nettype none
module tb_top
    import bsx_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        logic [15:0]     ins;
        logic [PC_W-1:0] pc;
        logic            ovf;
        logic [3:0]      bank;
        logic [7:0]      fd;
        logic            tw;
        logic            ld;
        logic [PC_W-1:0] tgt;
        logic [7:0]      wd;
        logic [3:0]      nop;
    } bsx_row_type;

    logic            i_core_clk      = 1'b0;
    logic            i_sys_rst       = 1'b1;
    logic [15:0]     i_instr         = 16'h0000;
    logic            i_instr_valid   = 1'b0;
    logic [PC_W-1:0] i_pc            = 21'h000000;
    logic            i_next_two_word = 1'b0;
    logic            i_ovf           = 1'b0;
    logic [3:0]      i_bank_sel      = 4'h0;
    logic [7:0]      i_fdata         = 8'h00;
    logic            o_rd_en;
    logic            o_wr_en;
    logic [11:0]     o_faddr;
    logic [7:0]      o_wdata;
    logic            o_pc_load;
    logic [PC_W-1:0] o_pc_target;
    logic            o_discard;
    logic            o_nop_cycle;
    logic [1:0]      o_phase;
    int              err_count       = 0;
    int              cmp_count       = 0;

    // wr data column only looked at for set/toggle rows
    bsx_row_type rows [17] = '{
        '{16'h8E20, 21'h1000, 1'b0, 4'h5, 8'h00, 1'b0, 1'b0, 21'h0, 8'h80, 4'h0},
        '{16'h8134, 21'h1000, 1'b0, 4'h5, 8'hFE, 1'b0, 1'b0, 21'h0, 8'hFF, 4'h0},
        '{16'h7690, 21'h1000, 1'b0, 4'h2, 8'hFF, 1'b0, 1'b0, 21'h0, 8'hF7, 4'h0},
        '{16'h7D01, 21'h1000, 1'b0, 4'hA, 8'h00, 1'b0, 1'b0, 21'h0, 8'h40, 4'h0},
        '{16'hB210, 21'h1000, 1'b0, 4'h1, 8'hFD, 1'b0, 1'b0, 21'h0, 8'h00, 4'h4},
        '{16'hB210, 21'h1000, 1'b0, 4'h1, 8'h02, 1'b0, 1'b0, 21'h0, 8'h00, 4'h0},
        '{16'hB210, 21'h1000, 1'b0, 4'h1, 8'h00, 1'b1, 1'b0, 21'h0, 8'h00, 4'h8},
        '{16'hAFFF, 21'h1000, 1'b0, 4'h3, 8'h80, 1'b0, 1'b0, 21'h0, 8'h00, 4'h4},
        '{16'hAFFF, 21'h1000, 1'b0, 4'h3, 8'h7F, 1'b1, 1'b0, 21'h0, 8'h00, 4'h0},
        '{16'hAFFF, 21'h1000, 1'b0, 4'h3, 8'hFF, 1'b1, 1'b0, 21'h0, 8'h00, 4'h8},
        '{16'hD005, 21'h1FFFFE, 1'b0, 4'h0, 8'h00, 1'b0, 1'b1, 21'h000008, 8'h00, 4'h4},
        '{16'hD400, 21'h1000, 1'b0, 4'h0, 8'h00, 1'b0, 1'b1, 21'h0800, 8'h00, 4'h4},
        '{16'hD3FF, 21'h1000, 1'b0, 4'h0, 8'h00, 1'b0, 1'b1, 21'h17FE, 8'h00, 4'h4},
        '{16'hE480, 21'h1000, 1'b1, 4'h0, 8'h00, 1'b0, 1'b1, 21'h0F00, 8'h00, 4'h4},
        '{16'hE47F, 21'h1000, 1'b1, 4'h0, 8'h00, 1'b0, 1'b1, 21'h10FE, 8'h00, 4'h4},
        '{16'hE405, 21'h1000, 1'b0, 4'h0, 8'h00, 1'b0, 1'b0, 21'h0, 8'h00, 4'h0},
        '{16'hE000, 21'h1000, 1'b1, 4'h0, 8'h00, 1'b0, 1'b0, 21'h0, 8'h00, 4'h0}
    };

    bsx_exec dut_u (
        .i_core_clk, .i_sys_rst, .i_instr, .i_instr_valid, .i_pc, .i_next_two_word,
        .i_ovf, .i_bank_sel, .i_fdata, .o_rd_en, .o_wr_en, .o_faddr, .o_wdata,
        .o_pc_load, .o_pc_target, .o_discard, .o_nop_cycle, .o_phase
    );

    always #2 i_core_clk = ~i_core_clk;

    task automatic conclude();
        if (err_count == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : conclude

    task automatic chkb(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t flag got %b exp %b", $time, got, exp);
        end
    endtask : chkb

    task automatic chkv(input logic [20:0] got, input logic [20:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t value got %0h exp %0h", $time, got, exp);
        end
    endtask : chkv

    task automatic chkn(input int got, input int exp);
        cmp_count++;
        if (got != exp) begin
            err_count++;
            $display("MISMATCH t=%0t idle clocks got %0d exp %0d", $time, got, exp);
        end
    endtask : chkn

    // access bank: low half of the page maps to bank 0, high half to bank F
    function automatic logic [11:0] fa(input logic [15:0] ins, input logic [3:0] bank);
        if (ins[8]) return {bank, ins[7:0]};
        return {(ins[7] ? 4'hF : 4'h0), ins[7:0]};
    endfunction : fa

    task automatic rst();
        @(posedge i_core_clk);
        i_sys_rst <= 1'b1;
        i_instr_valid <= 1'b0;
        repeat (2) @(posedge i_core_clk);
        i_sys_rst <= 1'b0;
        @(negedge i_core_clk);
        chkv(21'({o_rd_en, o_wr_en, o_pc_load, o_discard, o_nop_cycle, o_phase}), 21'h0);
    endtask : rst

    task automatic run(input bsx_row_type r);
        logic [3:0] op;
        logic       wr;
        logic       tst;
        int         n;
        op = r.ins[15:12];
        wr = (op == OPC_BIT_SET) || (op == OPC_BIT_TOGGLE);
        tst = (op == OPC_SKIP_CLR) || (op == OPC_SKIP_SET);
        @(posedge i_core_clk);
        i_instr <= r.ins;
        i_pc <= r.pc;
        i_ovf <= r.ovf;
        i_bank_sel <= r.bank;
        i_fdata <= r.fd;
        i_next_two_word <= r.tw;
        i_instr_valid <= 1'b1;
        // inputs held from here until after the taking edge
        for (n = 0; n < 16; n++) begin
            @(negedge i_core_clk);
            if (o_phase === PH_Q1 && o_nop_cycle === 1'b0) break;
        end
        @(negedge i_core_clk);
        chkb(o_rd_en, wr || tst);
        if (wr || tst) chkv(21'(o_faddr), 21'(fa(r.ins, r.bank)));
        @(posedge i_core_clk);
        i_instr_valid <= 1'b0;
        repeat (2) @(negedge i_core_clk);
        chkb(o_wr_en, wr);
        if (wr) chkv(21'(o_wdata), 21'(r.wd));
        chkb(o_pc_load, r.ld);
        if (r.ld) chkv(o_pc_target, r.tgt);
        chkb(o_discard, tst && r.nop != 4'h0);
        for (n = 0; n < 12; n++) begin
            @(negedge i_core_clk);
            if (o_nop_cycle !== 1'b1) break;
        end
        chkn(n, int'(r.nop));
    endtask : run

    initial begin
        #20000;
        err_count++;
        conclude();
    end

    initial begin
        rst();
        foreach (rows[i]) run(rows[i]);
        // branch cut off by reset before its write-back
        @(posedge i_core_clk);
        i_instr <= 16'hD005;
        i_instr_valid <= 1'b1;
        for (int k = 0; k < 8; k++) begin
            @(negedge i_core_clk);
            if (o_phase === PH_Q1) break;
        end
        // taken on the next edge, reset lands before its Q3 edge
        @(negedge i_core_clk);
        chkv(o_pc_target, 21'h00100A);
        rst();
        repeat (8) begin
            @(negedge i_core_clk);
            chkb(o_pc_load | o_rd_en, 1'b0);
        end
        run(rows[0]);
        conclude();
    end
endmodule : tb_top
`default_nettype wire
